// ### wan_serial_port_control.v
`timescale 1ns/1ps
`include "serial_port_map.vh"

// Function
// - DCE role by default, DTE selectable.
// - Bit rate 64 to 2304 kbps, default 2048.
// - Alternate bundling uses every other channel.
// - Arbitrary reported only, never accepted written.
// - Start channel 1-24 T1, 0-31 E1.
// - Timeslot count 0-24 T1, 0-32 E1.
// - Channel settings apply only under emulation.
// - Synchronous or asynchronous format, sync default.
// - Sample with internal or DTE clock.
// - External clock only allowed in packet mode.
// - Inversion samples on opposite clock edge.
// - Flow control none, XON/XOFF or RTS/CTS.
// - Five to eight data bits, eight default.
// - Parity none, odd or even.
// - One or two stop bits.
// - RTS from lead or forced asserted.
// - Internal CTS follows RTS after delay.
// - CTS forced on, off or internal.
// - Internal DCD follows network carrier.
// - Internal DSR follows port enable.
// - DTR low raises alarm when enabled.
module wan_serial_port_control
#(
  parameter CTS_NORM_CYCLES = (`CTS_DELAY_NORM_MS * `SYS_CLK_KHZ),
  parameter CTS_LONG_CYCLES = (`CTS_DELAY_LONG_MS * `SYS_CLK_KHZ),
  parameter RATE_DIV_W      = 16
)
(
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        rts_i,
  input  wire        dtr_i,
  input  wire        carrier_i,
  input  wire        ext_clk_i,
  input  wire        txd_i,
  output reg         cts_o,
  output reg         dcd_o,
  output reg         dsr_o,
  output reg         int_clk_o,
  output reg         sample_o,
  output reg         sample_data_o,
  output reg         dtr_alarm_o,
  output reg  [31:0] chan_map_o
);

  // ******************************************************************
  // Configuration registers
  // ******************************************************************
  // Software sees five words: port configuration, port rate in kbps,
  // channel placement, modem lead control and a read-only status word.
  // Rate, channel and bundling fields are checked before they are
  // stored; an illegal value there leaves the old setting in force.
  // Lead, framing and flow fields are stored unchecked, and the
  // external clock bit is stored as zero unless packet mode is set.
  // The framing and flow fields are only stored here. The
  // character engine that uses them sits elsewhere and reads them
  // back through this word. Keeping them together lets one write
  // switch the whole port at once.
  reg  [31:0] config_reg;
  reg  [11:0] rate_reg;
  reg  [5:0]  start_ch_reg;
  reg  [5:0]  ts_count_reg;
  reg  [31:0] leads_reg;

  // Range checks; a rejected field keeps its previous value.
  function valid_chan;
    input [5:0] start;
    input [5:0] count;
    input       e1;
    begin
      if (e1)
        valid_chan = (start <= 6'd31) && (count <= 6'd32);
      else
        valid_chan = (start >= 6'd1) && (start <= 6'd24) &&
                     (count <= 6'd24);
    end
  endfunction

  wire [1:0] wr_bund  = wdata_i[`CFG_BUND_LSB+1:`CFG_BUND_LSB];
  wire       wr_ext   = wdata_i[`CFG_EXT_CLK];
  wire       wr_pkt   = wdata_i[`CFG_PACKET];

  // Register writes with legality filtering of the rate, channel and bundling fields.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      config_reg   <= `RST_CONFIG;
      rate_reg     <= `RST_RATE_KBPS;
      start_ch_reg <= `RST_START_CH;
      ts_count_reg <= `RST_TS_COUNT;
      leads_reg    <= `RST_LEADS;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `REG_CONFIG:
        begin
          config_reg[15:0] <= wdata_i[15:0];
          // External clock stays off unless packet mode is requested.
          config_reg[`CFG_EXT_CLK] <= wr_ext & wr_pkt;
          // Arbitrary bundling is a reported value only.
          if (wr_bund != `BUND_ARBITRARY && wr_bund != 2'h3)
            config_reg[`CFG_BUND_LSB+1:`CFG_BUND_LSB] <= wr_bund;
        end
        `REG_RATE:
          if (wdata_i[11:0] >= `RATE_MIN_KBPS &&
              wdata_i[11:0] <= `RATE_MAX_KBPS && wdata_i[31:12] == 20'h0)
            rate_reg <= wdata_i[11:0];
        `REG_CHAN:
          if (valid_chan(wdata_i[5:0], wdata_i[13:8],
                         config_reg[`CFG_E1]))
          begin
            start_ch_reg <= wdata_i[5:0];
            ts_count_reg <= wdata_i[13:8];
          end
        `REG_LEADS:
          leads_reg <= {23'h0, wdata_i[8:0]};
        default:
          leads_reg <= leads_reg;
      endcase
    end
  end

  wire       role_dte  = config_reg[`CFG_ROLE_DTE];
  wire       ces       = config_reg[`CFG_CES];
  wire       ext_clk   = config_reg[`CFG_EXT_CLK] & config_reg[`CFG_PACKET];
  wire       invert    = config_reg[`CFG_INVERT];
  wire       port_en   = config_reg[`CFG_PORT_EN];
  wire [1:0] bund      = config_reg[`CFG_BUND_LSB+1:`CFG_BUND_LSB];
  wire [1:0] cts_mode  = leads_reg[`LD_CTS_LSB+1:`LD_CTS_LSB];
  wire [1:0] dcd_mode  = leads_reg[`LD_DCD_LSB+1:`LD_DCD_LSB];
  wire [1:0] dsr_mode  = leads_reg[`LD_DSR_LSB+1:`LD_DSR_LSB];
  wire       alarm_en  = leads_reg[`LD_DTR_ALARM_EN];

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  reg [4:0] meta_reg;
  reg [4:0] sync_reg;
  reg       link_prev_reg;
  // The selected link clock is declared here because the edge
  // detector below keeps its previous level in this same process.
  // Only the synchronised DTE clock or our own registered clock is
  // ever chosen, so the detector never reads a raw pin.
  wire      link_clk;

  // Two stages for every pin; only the second stage feeds logic.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg      <= 5'h00;
      sync_reg      <= 5'h00;
      link_prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg      <= {txd_i, ext_clk_i, carrier_i, dtr_i, rts_i};
      sync_reg      <= meta_reg;
      link_prev_reg <= link_clk;
    end
  end

  wire rts_pin   = sync_reg[0];
  wire dtr_pin   = sync_reg[1];
  wire carrier   = sync_reg[2];
  wire ext_clk_s = sync_reg[3];
  wire txd_s     = sync_reg[4];

  // ******************************************************************
  // Internal transmit clock divider
  // ******************************************************************
  // The divider runs all the time, also outside circuit emulation,
  // because the attached equipment expects a steady transmit clock
  // even while no data moves. A new rate takes effect at once, on the
  // running half period. If the new half period is shorter than the
  // running count, the output turns over at once. No half period is
  // ever shorter than one system cycle.
  // Half period in system cycles; rates that do not divide the
  // clock evenly come out slightly fast, a limit of one clock domain.
  reg  [RATE_DIV_W-1:0] div_cnt_reg;
  wire [31:0] half_full = (`SYS_CLK_KHZ / 2) / {20'h0, rate_reg};
  wire [RATE_DIV_W-1:0] half_per =
    (half_full[RATE_DIV_W-1:0] == {RATE_DIV_W{1'b0}}) ?
    {{(RATE_DIV_W-1){1'b0}}, 1'b1} : half_full[RATE_DIV_W-1:0];

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt_reg <= {RATE_DIV_W{1'b0}};
      int_clk_o   <= 1'b0;
    end
    else if (div_cnt_reg >= half_per - 1'b1)
    begin
      div_cnt_reg <= {RATE_DIV_W{1'b0}};
      int_clk_o   <= ~int_clk_o;
    end
    else
      div_cnt_reg <= div_cnt_reg + 1'b1;
  end

  // ******************************************************************
  // Data sampling
  // ******************************************************************
  // Sampling clock is our own transmit clock or the DTE clock.
  // Switching the clock source may show one false edge. That costs
  // at most one stray sample, which the framing logic drops, and it
  // avoids a glitch filter that would delay every real edge.
  // Inversion only swaps which of the two detected edges is used.
  assign link_clk = ext_clk ? ext_clk_s : int_clk_o;
  wire rise     = link_clk & ~link_prev_reg;
  wire fall     = ~link_clk & link_prev_reg;
  wire take     = invert ? fall : rise;

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sample_o      <= 1'b0;
      sample_data_o <= 1'b0;
    end
    else
    begin
      sample_o <= take;
      if (take)
        sample_data_o <= txd_s;
    end
  end

  // ******************************************************************
  // Modem control leads
  // ******************************************************************
  wire rts_eff = leads_reg[`LD_RTS_FORCE] | rts_pin;
  reg [31:0] cts_cnt_reg;
  reg        cts_int_reg;
  wire [31:0] cts_lim = leads_reg[`LD_LONG_DELAY] ?
                        CTS_LONG_CYCLES : CTS_NORM_CYCLES;

  // The counter only runs while the requested and shown states
  // differ. A short pulse on RTS therefore never reaches CTS. This
  // is the intended debounce, but a user must know that RTS has to
  // stay put for the whole delay before CTS answers. The delay is
  // counted in system cycles, so it scales with the system clock.
  // The delay restarts whenever RTS changes before it expires.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cts_cnt_reg <= 32'h0;
      cts_int_reg <= 1'b0;
    end
    else if (rts_eff == cts_int_reg)
      cts_cnt_reg <= 32'h0;
    else if (cts_cnt_reg >= cts_lim - 32'h1)
    begin
      cts_cnt_reg <= 32'h0;
      cts_int_reg <= rts_eff;
    end
    else
      cts_cnt_reg <= cts_cnt_reg + 32'h1;
  end

  function lead_out;
    input [1:0] mode;
    input       internal;
    begin
      case (mode)
        `LEAD_FORCE_ON:  lead_out = 1'b1;
        `LEAD_FORCE_OFF: lead_out = 1'b0;
        `LEAD_INTERNAL:  lead_out = internal;
        default:         lead_out = 1'b1;
      endcase
    end
  endfunction

  // Lead drivers and the DTR loss alarm.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cts_o       <= 1'b1;
      dcd_o       <= 1'b1;
      dsr_o       <= 1'b1;
      dtr_alarm_o <= 1'b0;
    end
    else
    begin
      cts_o       <= lead_out(cts_mode, cts_int_reg);
      dcd_o       <= lead_out(dcd_mode, carrier);
      dsr_o       <= lead_out(dsr_mode, port_en);
      dtr_alarm_o <= alarm_en & ~dtr_pin;
    end
  end

  // ******************************************************************
  // Channel map
  // ******************************************************************
  // The map is rebuilt from the settings every cycle rather than
  // kept as state. Stale channels cannot survive a change of start,
  // count or bundling that way. Channels beyond slot 31 are dropped,
  // also in T1, so a long alternate run stops at slot 31 instead of
  // wrapping round. Outside emulation the
  // map is empty, whatever the stored channel settings are.
  // Channels from the start, every other one in alternate mode.
  reg [31:0] map_next;
  reg [6:0]  idx;
  integer    n;
  always @*
  begin
    map_next = 32'h0;
    idx      = 7'h0;
    for (n = 0; n < 32; n = n + 1)
    begin
      idx = {1'b0, start_ch_reg} +
            ((bund == `BUND_ALTERNATE) ? n[5:0] << 1 : {1'b0, n[5:0]});
      if (ces && n < ts_count_reg && idx < 7'd32)
        map_next[idx[4:0]] = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      chan_map_o <= 32'h0;
    else
      chan_map_o <= map_next;
  end

  // ******************************************************************
  // Read port
  // ******************************************************************
  // Read data stand for exactly one cycle and are zero otherwise.
  // That keeps a shared read bus free of stale words. Status bits
  // show the registered lead outputs, so software reads the levels
  // that the attached equipment really sees. The DTR bit is the
  // synchronised pin, two cycles behind the pin itself. The role
  // bit lets software confirm the port side without a second read.
  // Status shows lead states and the alarm; unmapped reads return 0.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= 32'h0;
    else if (rd_i)
      case (addr_i)
        `REG_CONFIG: rdata_o <= config_reg;
        `REG_RATE:   rdata_o <= {20'h0, rate_reg};
        `REG_CHAN:   rdata_o <= {18'h0, ts_count_reg, 2'h0, start_ch_reg};
        `REG_LEADS:  rdata_o <= leads_reg;
        `REG_STATUS: rdata_o <= {25'h0, role_dte, dtr_alarm_o, dcd_o,
                                 cts_o, rts_eff, dsr_o, dtr_pin};
        default:     rdata_o <= 32'h0;
      endcase
    else
      rdata_o <= 32'h0;
  end

endmodule

// ### serial_port_map.vh
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
// Register byte offsets (one 32-bit word each).
`define REG_CONFIG        8'h00
`define REG_RATE          8'h04
`define REG_CHAN          8'h08
`define REG_LEADS         8'h0C
`define REG_STATUS        8'h10
// Config register field positions.
`define CFG_ROLE_DTE      0
`define CFG_ASYNC         1
`define CFG_CES           2
`define CFG_PACKET        3
`define CFG_EXT_CLK       4
`define CFG_INVERT        5
`define CFG_FLOW_LSB      6
`define CFG_SIZE_LSB      8
`define CFG_PARITY_LSB    10
`define CFG_TWO_STOP      12
`define CFG_E1            13
`define CFG_PORT_EN       14
`define CFG_BUND_LSB      16
// Leads register field positions.
`define LD_RTS_FORCE      0
`define LD_LONG_DELAY     1
`define LD_CTS_LSB        2
`define LD_DCD_LSB        4
`define LD_DSR_LSB        6
`define LD_DTR_ALARM_EN   8
// Lead modes.
`define LEAD_FORCE_ON     2'h0
`define LEAD_FORCE_OFF    2'h1
`define LEAD_INTERNAL     2'h2
// Bundling codes.
`define BUND_CONTIG       2'h0
`define BUND_ALTERNATE    2'h1
`define BUND_ARBITRARY    2'h2
// Reset values.
`define RST_CONFIG        32'h0000_4300
`define RST_RATE_KBPS     12'h800
`define RST_START_CH      6'h01
`define RST_TS_COUNT      6'h00
`define RST_LEADS         32'h0000_0000
// Rate limits in kbps.
`define RATE_MIN_KBPS     12'h040
`define RATE_MAX_KBPS     12'h900
// Delays in ms and clock in kHz.
`define CTS_DELAY_NORM_MS 30
`define CTS_DELAY_LONG_MS 100
`define SYS_CLK_KHZ       20000
`endif

// ### port_sva.sv
`timescale 1ns/1ps
// ***
// Pin relations of the serial port.
// ***
module port_sva
#(
  parameter CTS_NORM_CYCLES = 20
)
(
  input wire        sys_clk_i,
  input wire        rst_b_i,
  input wire        wr_i,
  input wire        rts_i,
  input wire        dtr_i,
  input wire        carrier_i,
  input wire        cts_o,
  input wire        dcd_o,
  input wire        dsr_o,
  input wire        int_clk_o,
  input wire        sample_o,
  input wire        dtr_alarm_o,
  input wire [31:0] chan_map_o
);
  reg [7:0]  wq;
  reg [31:0] rq;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Writes may move leads at once; pins must sit still first.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wq <= 8'h00;
      rq <= 32'h0;
    end
    else
    begin
      wq <= wr_i ? 8'h00 : wq + {7'h0, wq != 8'hFF};
      rq <= $changed(rts_i) ? 32'h0 : rq + {31'h0, rq < CTS_NORM_CYCLES};
    end
  end
  // Three samples cover two sync flops and the output flop.
  sequence s_dtr_up;
    dtr_i [*3];
  endsequence
  property p_alarm_set;
    dtr_alarm_o |-> !$past(dtr_i, 3);
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm w/o DTR low");
  property p_alarm_clr;
    s_dtr_up |=> !dtr_alarm_o;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm stuck");
  property p_lead_dflt;
    $rose(rst_b_i) |-> cts_o && dcd_o && dsr_o && !dtr_alarm_o
      && chan_map_o == 32'h0;
  endproperty
  a_lead_dflt: assert property (p_lead_dflt) else $error("bad reset leads");
  property p_clk_runs;
    1 |-> ##[1:200] $changed(int_clk_o);
  endproperty
  a_clk_runs: assert property (p_clk_runs) else $error("tx clock stopped");
  property p_clk_min;
    $changed(int_clk_o) |=> $stable(int_clk_o) [*3];
  endproperty
  a_clk_min: assert property (p_clk_min) else $error("tx clock too fast");
  property p_sample_gap;
    sample_o |=> !sample_o [*2];
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("sample burst");
  property p_cts_delay;
    $changed(cts_o) |-> wq < 8'h08 || rq >= CTS_NORM_CYCLES;
  endproperty
  a_cts_delay: assert property (p_cts_delay) else $error("CTS too early");
  property p_dcd_follow;
    $changed(dcd_o) |-> wq < 8'h08 || $past(carrier_i, 3) != $past(carrier_i, 4);
  endproperty
  a_dcd_follow: assert property (p_dcd_follow) else $error("DCD w/o carrier");
endmodule

bind wan_serial_port_control port_sva #(.CTS_NORM_CYCLES(CTS_NORM_CYCLES)) chk
  (.sys_clk_i, .rst_b_i, .wr_i, .rts_i, .dtr_i, .carrier_i, .cts_o, .dcd_o,
   .dsr_o, .int_clk_o, .sample_o, .dtr_alarm_o, .chan_map_o);

// ### dte_model.sv
`timescale 1ns/1ps
// ***
// Attached DTE: link clock and transmit data.
// ***
module dte_model
(
  input  wire run_i,
  input  wire on_rise_i,
  output reg  ext_clk_o,
  output reg  txd_o,
  output reg  held_o
);
  reg [7:0] pat_reg;
  // The clock idles low between bursts; data moves off the sample edge.
  initial
  begin
    {ext_clk_o, txd_o, held_o} = 3'h0;
    pat_reg = 8'hB4;
    forever
    begin
      #200;
      if (run_i || ext_clk_o)
        ext_clk_o = ~ext_clk_o;
      if (ext_clk_o == on_rise_i)
      begin
        pat_reg = {pat_reg[6:0], pat_reg[7] ^ pat_reg[5]};
        txd_o = pat_reg[0];
      end
      else
        held_o = txd_o;
    end
  end
endmodule

// ### test_wan_serial_port_control.sv
`timescale 1ns/1ps
`include "serial_port_map.vh"
// ***
// Bench
// ***
module test_wan_serial_port_control;
  reg         sys_clk_i, rst_b_i, wr_i, rd_i, rts_i, dtr_i, carrier_i;
  reg         run, on_rise;
  reg  [7:0]  addr_i;
  reg  [31:0] wdata_i, seed, v, e;
  wire        ext_clk_i, txd_i, held, cts_o, dcd_o, dsr_o, int_clk_o;
  wire        sample_o, sample_data_o, dtr_alarm_o;
  wire [31:0] rdata_o, chan_map_o;
  integer     num_errors, tests_run, i, nsmp;
  wan_serial_port_control #(.CTS_NORM_CYCLES(20), .CTS_LONG_CYCLES(50)) dut
    (.sys_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
     .rts_i, .dtr_i, .carrier_i, .ext_clk_i, .txd_i, .cts_o, .dcd_o, .dsr_o,
     .int_clk_o, .sample_o, .sample_data_o, .dtr_alarm_o, .chan_map_o);
  dte_model dte (.run_i(run), .on_rise_i(on_rise), .ext_clk_o(ext_clk_i),
    .txd_o(txd_i), .held_o(held));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [31:0] exp_map(input [5:0] s, input [5:0] n, input alt);
    integer k;
    begin
      exp_map = 32'h0;
      for (k = 0; k < n; k = k + 1)
        exp_map[s + (alt ? 2 * k : k)] = 1'b1;
    end
  endfunction
  task check32(input [31:0] g, input [31:0] x);
    begin
      tests_run = tests_run + 1;
      if (g !== x)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h want %h", $time, g, x);
      end
    end
  endtask
  task check1(input g, input x);
    check32({31'h0, g}, {31'h0, x});
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge sys_clk_i);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // Read data are taken in the one cycle that they stand.
  task rc(input [7:0] a, input [31:0] m, input [31:0] x);
    begin
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1;
      check32(rdata_o & m, x);
    end
  endtask
  task ces(input e1, input alt, input [5:0] s, input [5:0] n);
    begin
      wr(`REG_CONFIG, 32'h4004 | e1 << 13 | alt << 16);
      wr(`REG_CHAN, {18'h0, n, 2'h0, s});
      wt(2);
      check32(chan_map_o, exp_map(s, n, alt));
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Free clock and a watchdog well beyond the expected run.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #1000000;
    num_errors = num_errors + 1;
    final_report;
  end
  // Every sample taken while the DTE runs must carry the bit the DTE held at its sample edge.
  always @(posedge sys_clk_i)
    if (run && sample_o === 1'b1)
    begin
      nsmp = nsmp + 1;
      check1(sample_data_o, held);
    end
  initial
  begin
    {wr_i, rd_i, run, on_rise, rst_b_i, addr_i, wdata_i} = 45'h0;
    {rts_i, dtr_i, carrier_i} = 3'h7;
    {num_errors, tests_run, nsmp} = 96'h0;
    seed = 32'hF1EC9E0D;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rc(`REG_CONFIG, 32'h3FFFF, 32'h4300);
    rc(`REG_RATE, 32'hFFF, 32'h800);
    rc(`REG_CHAN, 32'h3F3F, 32'h1);
    rc(`REG_LEADS, 32'h1FF, 32'h0);
    rc(`REG_STATUS, 32'h60, 32'h0);
    rc(8'hFC, 32'hFFFFFFFF, 32'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = xs(seed);
      if (i < 6)
        e = i == 0 ? 32'h40 : i == 1 ? 32'h900 : 32'h40 + seed % 32'h8C1;
      if (i > 5)
        wr(`REG_RATE, i == 6 ? 32'h901 : 32'h3F);
      else
        wr(`REG_RATE, e);
      rc(`REG_RATE, 32'hFFF, e);
      v = 32'h4002 | (seed % 3) << 6 | seed[9:8] << 8
        | (seed[23:16] % 3) << 10 | seed[12] << 12;
      wr(`REG_CONFIG, v);
      rc(`REG_CONFIG, 32'h1FC2, v & 32'h1FC2);
    end
    wr(`REG_CONFIG, 32'h4010);
    rc(`REG_CONFIG, 32'h18, 32'h0);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(`REG_CONFIG, 32'h4018 | i << 5);
      on_rise = i;
      nsmp = 0;
      run = 1'b1;
      wt(200);
      run = 1'b0;
      check1(nsmp > 20 && nsmp < 30, 1'b1);
      wt(20);
    end
    ces(0, 0, 3, 4);
    ces(1, 0, 0, 32);
    ces(1, 1, 0, 16);
    ces(0, 0, 24, 1);
    ces(0, 0, 1, 0);
    wr(`REG_CHAN, 32'h0100);
    wr(`REG_CHAN, 32'h1901);
    rc(`REG_CHAN, 32'h3F3F, 32'h1);
    ces(0, 1, 3, 4);
    wr(`REG_CONFIG, 32'h24004);
    rc(`REG_CONFIG, 32'h30000, 32'h10000);
    wr(`REG_CONFIG, 32'h4001);
    rc(`REG_STATUS, 32'h40, 32'h40);
    wt(2);
    check32(chan_map_o, 32'h0);
    wr(`REG_CONFIG, 32'h4000);
    wr(`REG_LEADS, 32'h1A8);
    @(posedge sys_clk_i) carrier_i <= 1'b0;
    wt(5);
    check1(dcd_o, 1'b0);
    wr(`REG_CONFIG, 32'h0);
    wt(4);
    check1(dsr_o, 1'b0);
    wr(`REG_CONFIG, 32'h4000);
    wt(4);
    check1(dsr_o, 1'b1);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(`REG_LEADS, 32'h1A8 | i << 1);
      @(posedge sys_clk_i) rts_i <= 1'b0;
      wt(i ? 40 : 10);
      check1(cts_o, 1'b1);
      wt(i ? 30 : 20);
      check1(cts_o, 1'b0);
      @(posedge sys_clk_i) rts_i <= 1'b1;
      wt(80);
    end
    wr(`REG_LEADS, 32'h1A4);
    wt(4);
    check1(cts_o, 1'b0);
    wr(`REG_LEADS, 32'h1A9);
    @(posedge sys_clk_i) rts_i <= 1'b0;
    wt(40);
    check1(cts_o, 1'b1);
    rc(`REG_STATUS, 32'h4, 32'h4);
    wr(`REG_LEADS, 32'h1A8);
    wt(30);
    check1(cts_o, 1'b0);
    @(posedge sys_clk_i) dtr_i <= 1'b0;
    wt(5);
    check1(dtr_alarm_o, 1'b1);
    rc(`REG_STATUS, 32'h21, 32'h20);
    @(posedge sys_clk_i) dtr_i <= 1'b1;
    wt(5);
    check1(dtr_alarm_o, 1'b0);
    @(posedge sys_clk_i) dtr_i <= 1'b0;
    wt(5);
    wr(`REG_LEADS, 32'hA8);
    wt(4);
    check1(dtr_alarm_o, 1'b0);
    @(posedge sys_clk_i) rst_b_i <= 1'b0;
    wt(3);
    rst_b_i <= 1'b1;
    rc(`REG_LEADS, 32'h1FF, 32'h0);
    final_report;
  end
endmodule
